// file: design/screen_block_map.vh
`ifndef SCREEN_BLOCK_MAP_VH
`define SCREEN_BLOCK_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_BLOCK3_BASE_LOW  16'h8011
`define ADDR_BLOCK3_BASE_HIGH 16'h8012
`define ADDR_BLOCK4_BASE_LOW  16'h8013
`define ADDR_BLOCK4_BASE_HIGH 16'h8014

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BASE_BYTE 8'h00
`define RST_BASE_WORD 16'h0000
`define RST_LINES     8'h00

`endif

// file: design/base_pair.v
`timescale 1ns/10ps
`include "screen_block_map.vh"

// Byte-wise loaded start address: low byte is shadowed, high byte commits both.
module base_pair
(
    // Clock and reset
    input  wire        clock_in,
    input  wire        rst_in,
    input  wire        ce_in,
    // Byte writes
    input  wire        wr_low_in,
    input  wire        wr_high_in,
    input  wire [7:0]  wdata_in,
    // State
    output reg  [7:0]  low_shadow_out,
    output reg  [15:0] base_out
);

    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            low_shadow_out <= `RST_BASE_BYTE;
            base_out       <= `RST_BASE_WORD;
        end
        else if (ce_in)
        begin
            if (wr_low_in)
                low_shadow_out <= wdata_in;
            // Low byte from the shadow, so a lone low write never moves the address
            if (wr_high_in)
                base_out <= {wdata_in, low_shadow_out};
        end
    end

endmodule

// file: design/screen_block_layer_setup.v
`timescale 1ns/10ps
`include "screen_block_map.vh"

module screen_block_layer_setup
#(
    parameter AW = 16
)
(
    // Clock, reset, enable
    input  wire          clock_in,
    input  wire          rst_in,
    input  wire          ce_in,
    // Host register port
    input  wire [AW-1:0] addr_in,
    input  wire          wr_in,
    input  wire          rd_in,
    input  wire [7:0]    wdata_in,
    output reg  [7:0]    rdata_out,
    // Other block sizes, as programmed (lines minus one)
    input  wire [7:0]    first_block_lines_in,
    input  wire [7:0]    second_block_lines_in,
    input  wire [7:0]    frame_lines_in,
    input  wire          dual_panel_in,
    // To display refresh
    output reg  [15:0]   third_block_base_out,
    output reg  [15:0]   fourth_block_base_out,
    output reg  [7:0]    third_block_lines_out,
    output reg  [7:0]    fourth_block_lines_out,
    output reg  [7:0]    first_blank_lines_out,
    output reg  [7:0]    second_blank_lines_out
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function hit;
        input [AW-1:0] a;
        input [15:0]   target;
        begin
            hit = (a == target[AW-1:0]);
        end
    endfunction

    wire       wr_3l = wr_in & hit(addr_in, `ADDR_BLOCK3_BASE_LOW);
    wire       wr_3h = wr_in & hit(addr_in, `ADDR_BLOCK3_BASE_HIGH);
    wire       wr_4l = wr_in & hit(addr_in, `ADDR_BLOCK4_BASE_LOW);
    wire       wr_4h = wr_in & hit(addr_in, `ADDR_BLOCK4_BASE_HIGH);

    wire [7:0]  sh3;
    wire [7:0]  sh4;
    wire [15:0] base3;
    wire [15:0] base4;

    base_pair u_third
    (
        .clock_in       (clock_in),
        .rst_in         (rst_in),
        .ce_in          (ce_in),
        .wr_low_in      (wr_3l),
        .wr_high_in     (wr_3h),
        .wdata_in       (wdata_in),
        .low_shadow_out (sh3),
        .base_out       (base3)
    );

    base_pair u_fourth
    (
        .clock_in       (clock_in),
        .rst_in         (rst_in),
        .ce_in          (ce_in),
        .wr_low_in      (wr_4l),
        .wr_high_in     (wr_4h),
        .wdata_in       (wdata_in),
        .low_shadow_out (sh4),
        .base_out       (base4)
    );

    // ----------------------------------------------------------------
    // Derived line counts and dual-panel blanking
    // ----------------------------------------------------------------
    reg  [7:0] lines3_d;
    reg  [7:0] half_d;
    reg  [7:0] blank1_d;
    reg  [7:0] blank2_d;
    reg  [8:0] frame_p1;
    reg  [7:0] rdata_d;

    // Distance between a programmed size and the half-frame size
    function [7:0] gap;
        input [7:0] size;
        input [7:0] half;
        begin
            // Taken as absolute, so a short block is blanked as well as a long one
            if (size > half)
                gap = size - half;
            else
                gap = half - size;
        end
    endfunction

    always @*
    begin
        lines3_d = (first_block_lines_in < second_block_lines_in) ?
                   first_block_lines_in : second_block_lines_in;
    end

    // ----------------------------------------------------------------
    // Dual-panel blanking
    // ----------------------------------------------------------------
    always @*
    begin
        // Half of (frame lines + 1), in the same minus-one encoding
        frame_p1 = {1'b0, frame_lines_in} + 9'h001;
        half_d   = frame_p1[8:1] - 8'h01;
        blank1_d = 8'h00;
        blank2_d = 8'h00;
        if (dual_panel_in)
        begin
            blank1_d = gap(first_block_lines_in, half_d);
            blank2_d = gap(second_block_lines_in, half_d);
        end
    end

    // ----------------------------------------------------------------
    // Read-back select
    // ----------------------------------------------------------------
    // Low bytes read back the shadow, high bytes the committed value
    always @*
    begin
        rdata_d = 8'h00;
        if (hit(addr_in, `ADDR_BLOCK3_BASE_LOW))
            rdata_d = sh3;
        else if (hit(addr_in, `ADDR_BLOCK3_BASE_HIGH))
            rdata_d = base3[15:8];
        else if (hit(addr_in, `ADDR_BLOCK4_BASE_LOW))
            rdata_d = sh4;
        else if (hit(addr_in, `ADDR_BLOCK4_BASE_HIGH))
            rdata_d = base4[15:8];
    end

    // ----------------------------------------------------------------
    // Committed start addresses
    // ----------------------------------------------------------------
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            third_block_base_out  <= `RST_BASE_WORD;
            fourth_block_base_out <= `RST_BASE_WORD;
        end
        else if (ce_in)
        begin
            third_block_base_out  <= base3;
            fourth_block_base_out <= base4;
        end
    end

    // ----------------------------------------------------------------
    // Derived line counts
    // ----------------------------------------------------------------
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            third_block_lines_out  <= `RST_LINES;
            fourth_block_lines_out <= `RST_LINES;
        end
        else if (ce_in)
        begin
            third_block_lines_out  <= lines3_d;
            // Block four runs to the end of the frame, so it follows frame lines
            fourth_block_lines_out <= frame_lines_in;
        end
    end

    // ----------------------------------------------------------------
    // Blanking outputs
    // ----------------------------------------------------------------
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            first_blank_lines_out  <= `RST_LINES;
            second_blank_lines_out <= `RST_LINES;
        end
        else if (ce_in)
        begin
            first_blank_lines_out  <= blank1_d;
            second_blank_lines_out <= blank2_d;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Read data holds between reads, so a slow host may take it late
    always @(posedge clock_in)
    begin
        if (rst_in)
            rdata_out <= `RST_BASE_BYTE;
        else if (ce_in && rd_in)
            rdata_out <= rdata_d;
    end

endmodule

// file: tb/layer_setup_asserts.sv
`timescale 1ns/10ps
module layer_setup_asserts
#(
    parameter AW = 16
)
(
    input wire          clock_in, rst_in, ce_in, wr_in, dual_panel_in,
    input wire [AW-1:0] addr_in,
    input wire [15:0]   third_block_base_out, fourth_block_base_out,
    input wire [7:0]    wdata_in, first_block_lines_in, second_block_lines_in, frame_lines_in,
    input wire [7:0]    third_block_lines_out, fourth_block_lines_out, first_blank_lines_out, second_blank_lines_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    wire wr4 = ce_in && wr_in && addr_in == 16'h8014;
    wire wr3 = ce_in && wr_in && addr_in == 16'h8012;
    a_fourth_commit: assert property (wr4 |-> ##2 fourth_block_base_out[15:8] == $past(wdata_in, 2))
        else $error("fourth base high byte wrong");
    a_fourth_hold: assert property ($changed(fourth_block_base_out) |-> $past(wr4, 2))
        else $error("fourth base moved without high write");
    a_third_commit: assert property (wr3 |-> ##2 third_block_base_out[15:8] == $past(wdata_in, 2))
        else $error("third base high byte wrong");
    a_third_lines: assert property (!$past(rst_in) && $stable(first_block_lines_in) && $stable(second_block_lines_in)
        |-> third_block_lines_out == ((first_block_lines_in < second_block_lines_in) ? first_block_lines_in
        : second_block_lines_in)) else $error("third lines not the minimum");
    a_fourth_lines: assert property (!$past(rst_in) && $stable(frame_lines_in)
        |-> fourth_block_lines_out == frame_lines_in) else $error("fourth lines not frame lines");
    a_blank_off: assert property (!$past(rst_in) && !dual_panel_in && $stable(dual_panel_in)
        |-> first_blank_lines_out == 8'h00 && second_blank_lines_out == 8'h00) else $error("blanking in single panel");
    c_wr4: cover property (wr4);
    c_wr3: cover property (wr3);
    c_dual: cover property (dual_panel_in && first_blank_lines_out != 8'h00);
endmodule

bind screen_block_layer_setup layer_setup_asserts #(.AW(AW)) u_chk (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
    .wr_in(wr_in), .dual_panel_in(dual_panel_in), .addr_in(addr_in), .third_block_base_out(third_block_base_out),
    .fourth_block_base_out(fourth_block_base_out), .wdata_in(wdata_in), .first_block_lines_in(first_block_lines_in),
    .second_block_lines_in(second_block_lines_in), .frame_lines_in(frame_lines_in),
    .third_block_lines_out(third_block_lines_out), .fourth_block_lines_out(fourth_block_lines_out),
    .first_blank_lines_out(first_blank_lines_out), .second_blank_lines_out(second_blank_lines_out));

// file: tb/host_model.sv
`timescale 1ns/10ps
module host_model
(
    input  wire        clock_in,
    input  wire [7:0]  rdata_in,
    output reg  [15:0] addr_out = 16'h0000,
    output reg         wr_out = 1'b0,
    output reg         rd_out = 1'b0,
    output reg  [7:0]  wdata_out = 8'h00
);
    task wr8(input [15:0] a, input [7:0] d);
    begin
        @(posedge clock_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clock_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    end
    endtask
    // Read data is registered, so it is taken just after the second edge following the strobe
    task rd8(input [15:0] a, output [7:0] d);
    begin
        @(posedge clock_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clock_in);
        rd_out <= 1'b0;
        @(posedge clock_in);
        #1 d = rdata_in;
    end
    endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    reg         clock_in = 1'b0, rst_in = 1'b1, dual = 1'b0, ce = 1'b1;
    reg  [7:0]  l1 = 8'h10, l2 = 8'h05, lf = 8'hEF, v;
    wire [15:0] addr, b3, b4;
    wire        wr, rd;
    wire [7:0]  wdata, rdata, l3, l4, k1, k2;
    integer     n_fail = 0, n_compared = 0, cyc = 0;
    always #50 clock_in = ~clock_in;
    host_model u_host (.clock_in(clock_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
        .wdata_out(wdata));
    screen_block_layer_setup u_dut (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce), .addr_in(addr),
        .wr_in(wr), .rd_in(rd), .wdata_in(wdata), .rdata_out(rdata), .first_block_lines_in(l1),
        .second_block_lines_in(l2), .frame_lines_in(lf), .dual_panel_in(dual), .third_block_base_out(b3),
        .fourth_block_base_out(b4), .third_block_lines_out(l3), .fourth_block_lines_out(l4),
        .first_blank_lines_out(k1), .second_blank_lines_out(k2));
    task chk(input string name, input [15:0] seen, input [15:0] exp);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("Error %0s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    task summarize;
    begin
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task pause;
    begin
        repeat (2) @(posedge clock_in);
        #1;
    end
    endtask
    // Generous ceiling: the whole sequence needs well under 100 cycles
    always @(posedge clock_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            n_fail = n_fail + 1;
            summarize;
        end
    end
    initial
    begin
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        u_host.rd8(16'h8014, v);
        chk("fourth high reset", v, 8'h00);
        u_host.wr8(16'h8013, 8'h34);
        pause;
        chk("fourth base after low", b4, 16'h0000);
        u_host.wr8(16'h8014, 8'h12);
        pause;
        chk("fourth base", b4, 16'h1234);
        u_host.wr8(16'h8011, 8'hCD);
        u_host.wr8(16'h8012, 8'hAB);
        pause;
        chk("third base", b3, 16'hABCD);
        u_host.rd8(16'h8011, v);
        chk("third low read", v, 8'hCD);
        u_host.rd8(16'h8000, v);
        chk("unmapped read", v, 8'h00);
        $display("test bases done");
        chk("third lines", l3, 8'h05);
        chk("fourth lines", l4, 8'hEF);
        chk("blank single", k1, 8'h00);
        @(posedge clock_in);
        dual <= 1'b1;
        pause;
        chk("first blank", k1, 8'h67);
        chk("second blank", k2, 8'h72);
        $display("test lines done");
        @(posedge clock_in);
        ce <= 1'b0;
        u_host.wr8(16'h8013, 8'h56);
        u_host.wr8(16'h8014, 8'h78);
        pause;
        chk("fourth base frozen", b4, 16'h1234);
        @(posedge clock_in);
        ce <= 1'b1;
        $display("test enable done");
        summarize;
    end
endmodule
